// ==== tb.sv ====
// self-checking bench for the 8-bit waveform timer, driven through its register port
// assumes tpwm_pkg and tpwm_timer are compiled first; assertions live in the design files
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpwm_pkg::*;

  // ****************************************
  // signals and design
  // ****************************************
  logic clk_i, arst_n_i, ce_i, tick_i, wr_i, rd_i, dir_out_i, ovf_ack_i, cmpa_ack_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, timer_count_o, seen;
  logic compare_output_a_o, compare_output_a_oe_o, ovf_irq_o, cmpa_irq_o;
  int num_errors = 0;
  int checked = 0;
  int highs, toggles;
  typedef struct {logic [7:0] ctrl; logic [7:0] cmp; int settle; int n; int highs; int toggles; logic [7:0] cnt;}
    tpwm_case_t;
  tpwm_case_t cases [14];

  tpwm_timer DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .tick_i(tick_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dir_out_i(dir_out_i),
    .compare_output_a_o(compare_output_a_o), .compare_output_a_oe_o(compare_output_a_oe_o),
    .ovf_ack_i(ovf_ack_i), .cmpa_ack_i(cmpa_ack_i), .ovf_irq_o(ovf_irq_o), .cmpa_irq_o(cmpa_irq_o),
    .timer_count_o(timer_count_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ****************************************
  // comparisons and verdict
  // ****************************************
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, got %h", what, exp, got);
    end
  endtask

  task automatic check_num(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d, got %0d", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // register port and tick driving
  // ****************************************
  task automatic do_reset;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample right after that edge
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // exactly n timer ticks; counts high samples and level changes of the compare output
  task automatic run(input int n);
    logic prev;
    prev = compare_output_a_o;
    highs = 0;
    toggles = 0;
    if (n > 0) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (i == n - 1) tick_i <= 1'b0;
      #1;
      if (compare_output_a_o !== prev) toggles++;
      if (compare_output_a_o === 1'b1) highs++;
      prev = compare_output_a_o;
    end
  endtask

  task automatic pulse_ack(input logic which_cmp);
    @(posedge clk_i);
    ovf_ack_i <= !which_cmp;
    cmpa_ack_i <= which_cmp;
    @(posedge clk_i);
    ovf_ack_i <= 1'b0;
    cmpa_ack_i <= 1'b0;
    #1;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {ce_i, dir_out_i} = 2'b11;
    {arst_n_i, tick_i, wr_i, rd_i, ovf_ack_i, cmpa_ack_i} = 6'h00;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    // ctrl, compare, settle ticks, measured ticks, high samples, toggles, final count (-1 = not judged)
    cases = '{
      '{8'h42, 8'h02, 0, 12, 6, 4, 8'h00},
      '{8'h02, 8'h02, 0, 12, 0, 0, 8'h00},
      '{8'h83, 8'h40, 256, 256, 65, 2, 8'h00},
      '{8'hC3, 8'h40, 256, 256, 191, 2, 8'h00},
      '{8'h43, 8'h40, 256, 512, -1, 2, 8'h00},
      '{8'h83, 8'h00, 256, 256, 1, 2, 8'h00},
      '{8'h83, 8'hFF, 256, 256, 256, 0, 8'h00},
      '{8'hC7, 8'h40, 0, 100, -1, -1, 8'h23},
      '{8'h81, 8'h40, 1020, 510, 128, 2, 8'h00},
      '{8'hC1, 8'h40, 1020, 510, 382, 2, 8'h00},
      '{8'h81, 8'h00, 1020, 510, 0, 0, 8'h00},
      '{8'h81, 8'hFF, 1020, 510, 510, 0, 8'h00},
      '{8'hC1, 8'hFF, 1020, 510, 0, 0, 8'h00},
      '{8'h85, 8'h40, 0, 100, -1, -1, 8'h1C}
    };
    foreach (cases[i]) begin
      do_reset();
      wr_reg(TPWM_ADDR_CTRL, 8'h02);
      wr_reg(TPWM_ADDR_CMPA, cases[i].cmp);
      wr_reg(TPWM_ADDR_CTRL, cases[i].ctrl);
      run(cases[i].settle);
      run(cases[i].n);
      check_val("count", cases[i].cnt, timer_count_o);
      if (cases[i].highs >= 0) check_num("high samples", cases[i].highs, highs);
      if (cases[i].toggles >= 0) check_num("toggles", cases[i].toggles, toggles);
    end
    // a compare value below the count is missed until the wrap through 0xFF
    do_reset();
    wr_reg(TPWM_ADDR_CTRL, 8'h42);
    wr_reg(TPWM_ADDR_CMPA, 8'h02);
    wr_reg(TPWM_ADDR_IRQEN, 8'h03);
    wr_reg(TPWM_ADDR_COUNT, 8'h05);
    rd_reg(TPWM_ADDR_CTRL, seen);
    check_val("ctrl readback", 8'h42, seen);
    rd_reg(3'h5, seen);
    check_val("unmapped read", 8'h00, seen);
    run(250);
    check_val("count at max", 8'hFF, timer_count_o);
    check_num("toggles before wrap", 0, toggles);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("flags before wrap", 8'h00, seen);
    run(1);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("flags after wrap", 8'h01, seen);
    check_val("overflow request", 8'h01, {7'h00, ovf_irq_o});
    pulse_ack(1'b0);
    check_val("overflow request", 8'h00, {7'h00, ovf_irq_o});
    run(3);
    check_num("toggles after wrap", 1, toggles);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("flags at top", 8'h02, seen);
    check_val("compare request", 8'h01, {7'h00, cmpa_irq_o});
    wr_reg(TPWM_ADDR_FLAGS, 8'h02);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("flags after clear", 8'h00, seen);
    run(3);
    pulse_ack(1'b1);
    check_val("compare request", 8'h00, {7'h00, cmpa_irq_o});
    check_val("pin enable", 8'h01, {7'h00, compare_output_a_oe_o});
    @(posedge clk_i);
    dir_out_i <= 1'b0;
    #1 check_val("pin enable", 8'h00, {7'h00, compare_output_a_oe_o});
    // a write with the clock enable low must not land
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr_reg(TPWM_ADDR_COUNT, 8'h77);
    ce_i <= 1'b1;
    rd_reg(TPWM_ADDR_COUNT, seen);
    check_val("frozen count", 8'h00, seen);
    // dual slope turns at top after one tick there; overflow at bottom
    do_reset();
    wr_reg(TPWM_ADDR_CTRL, 8'h81);
    run(255);
    check_val("count at top", 8'hFF, timer_count_o);
    run(1);
    check_val("count after top", 8'hFE, timer_count_o);
    run(254);
    wr_reg(TPWM_ADDR_FLAGS, 8'h03);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("overflow before bottom", 8'h00, seen & 8'h01);
    run(1);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("overflow at bottom", 8'h01, seen & 8'h01);
    // single slope overflow as the counter leaves top
    do_reset();
    wr_reg(TPWM_ADDR_CTRL, 8'h83);
    run(255);
    wr_reg(TPWM_ADDR_FLAGS, 8'h03);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("overflow before top", 8'h00, seen & 8'h01);
    run(1);
    rd_reg(TPWM_ADDR_FLAGS, seen);
    check_val("overflow at top", 8'h01, seen & 8'h01);
    // dual slope: an up match skipped by a count write still sets the inverted output
    do_reset();
    wr_reg(TPWM_ADDR_CTRL, 8'h02);
    wr_reg(TPWM_ADDR_CMPA, 8'h40);
    wr_reg(TPWM_ADDR_CTRL, 8'hC1);
    wr_reg(TPWM_ADDR_COUNT, 8'h80);
    run(1);
    check_val("output after missed match", 8'h01, {7'h00, compare_output_a_o});
    // compare A leaving max: the next bottom brings the up-match level without a match
    do_reset();
    wr_reg(TPWM_ADDR_CTRL, 8'h02);
    wr_reg(TPWM_ADDR_CMPA, 8'hFF);
    wr_reg(TPWM_ADDR_CTRL, 8'h81);
    run(600);
    wr_reg(TPWM_ADDR_CMPA, 8'h40);
    run(421);
    check_num("toggles after leaving max", 1, toggles);
    check_val("output after leaving max", 8'h00, {7'h00, compare_output_a_o});
    report_and_stop();
  end

  // the tests need about 13000 cycles; this leaves ample margin
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== tpwm_cmp_buf.sv ====
// compare value A holder: software shadow plus the value the comparator uses
// assumes update_i is a one-cycle strobe from the counter at top or bottom
`timescale 1ns/1ps
`default_nettype none
module tpwm_cmp_buf
  import tpwm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // software side
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // counter side
  input wire logic direct_i,
  input wire logic update_i,
  output logic [7:0] shadow_o,
  output logic [7:0] live_o
);
  typedef struct packed {
    logic [7:0] shadow;
    logic [7:0] live;
  } tpwm_buf_st_t;

  tpwm_buf_st_t q, d;

  always_comb begin
    d = q;
    if (ce_i) begin
      if (update_i) begin
        d.live = q.shadow;
      end
      if (wr_i) begin
        d.shadow = wdata_i;
        if (direct_i) begin
          d.live = wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{shadow: TPWM_CMP_RST, live: TPWM_CMP_RST};
    end else begin
      q <= d;
    end
  end

  assign shadow_o = q.shadow;
  assign live_o = q.live;
endmodule
`default_nettype wire

// ==== tpwm_pkg.sv ====
// constants and state types for the 8-bit waveform timer
// assumes a single clock, a prescaled tick enable and a byte-wide register port
package tpwm_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [2:0] TPWM_ADDR_CTRL = 3'h0;
  localparam logic [2:0] TPWM_ADDR_COUNT = 3'h1;
  localparam logic [2:0] TPWM_ADDR_CMPA = 3'h2;
  localparam logic [2:0] TPWM_ADDR_FLAGS = 3'h3;
  localparam logic [2:0] TPWM_ADDR_IRQEN = 3'h4;
  localparam int unsigned TPWM_CTRL_ACT_LSB = 6;
  localparam int unsigned TPWM_CTRL_WGM_LSB = 0;
  localparam int unsigned TPWM_FLAG_OVF_BIT = 0;
  localparam int unsigned TPWM_FLAG_CMPA_BIT = 1;

  // ****************************************
  // reset values and count limits
  // ****************************************
  localparam logic [7:0] TPWM_BOTTOM = 8'h00;
  localparam logic [7:0] TPWM_MAX = 8'hFF;
  localparam logic [7:0] TPWM_CNT_RST = 8'h00;
  localparam logic [7:0] TPWM_CMP_RST = 8'h00;
  localparam logic [7:0] TPWM_ONE = 8'h01;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [2:0] {
    TPWM_WGM_NORMAL = 3'b000,
    TPWM_WGM_PC_MAX = 3'b001,
    TPWM_WGM_CTC = 3'b010,
    TPWM_WGM_FAST_MAX = 3'b011,
    TPWM_WGM_RSV4 = 3'b100,
    TPWM_WGM_PC_CMP = 3'b101,
    TPWM_WGM_RSV6 = 3'b110,
    TPWM_WGM_FAST_CMP = 3'b111
  } tpwm_wgm_t;

  typedef enum logic [1:0] {
    TPWM_ACT_NONE = 2'b00,
    TPWM_ACT_TOGGLE = 2'b01,
    TPWM_ACT_CLEAR = 2'b10,
    TPWM_ACT_SET = 2'b11
  } tpwm_act_t;

  typedef enum logic {
    TPWM_DIR_UP = 1'b0,
    TPWM_DIR_DOWN = 1'b1
  } tpwm_dir_t;

endpackage

// ==== tpwm_timer.sv ====
// 8-bit timer with clear-on-compare, fast pwm and phase-correct pwm modes
// assumes tick_i is the prescaled timer enable, synchronous to clk_i
//
// Overview of operation
// - mode 2 clears the counter after it matches compare A, so A is top.
// - mode 2 writes to compare A act at once; a missed match wraps via 0xFF.
// - mode 2 sets the compare A flag at top; an enabled flag requests interrupt.
// - mode 2 with action 1 toggles compare output A on each match.
// - the pin shows compare output A only while its direction is output.
// - toggle in mode 2 gives clock over 2 times prescale times one plus A.
// - mode 2 sets the overflow flag as the counter passes from max to zero.
// - modes 3 and 7 are fast pwm with top 0xFF or compare A.
// - fast pwm counts up to top then loads zero next tick.
// - fast pwm action 2 clears on match, sets at bottom; action 3 opposite.
// - fast pwm sets the overflow flag each time the counter reaches top.
// - fast pwm period is 256 ticks of the prescaled clock in mode 3, one plus A in mode 7.
// - fast pwm compare at bottom gives a spike, at max a constant level.
// - fast pwm action 1 toggles on each match, compare stays double buffered.
// - modes 1 and 5 count up to top then back down to bottom.
// - phase-correct turns at top and holds top for one tick.
// - phase-correct clears on up match and sets on down match; inverted swaps.
// - phase-correct sets the overflow flag each time the counter reaches bottom.
// - phase-correct period is 510 ticks of the prescaled clock in mode 1, twice A in mode 5.
// - phase-correct compare at bottom holds low, at max holds high, inverted swaps.
// - compare A leaving max makes the up-match change at the next period start.
// - an up match missed by starting above compare still changes the output.
// - a match sets the compare flag; interrupt entry or writing one clears it.
// - pwm modes update compare A at top or bottom; mode 2 writes go direct.
// - action 0 leaves compare output A unchanged in every mode.
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer
  import tpwm_pkg::*;
(
  // clock, reset, enables
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // pin
  input wire logic dir_out_i,
  output logic compare_output_a_o,
  output logic compare_output_a_oe_o,
  // interrupt requests
  input wire logic ovf_ack_i,
  input wire logic cmpa_ack_i,
  output logic ovf_irq_o,
  output logic cmpa_irq_o,
  // status
  output logic [7:0] timer_count_o
);
  import tpwm_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] cnt;
    tpwm_dir_t dir;
    logic ovf;
    logic cmpa;
    logic blk;
    tpwm_wgm_t wgm;
    tpwm_act_t act;
    logic [1:0] irq_en;
    logic [7:0] rdata;
  } tpwm_core_t;

  tpwm_core_t q, d;
  logic adv, is_ctc, is_fast, is_pc, top_cmp, match, at_top;
  logic cnt_wr, cmp_wr, cmp_upd, ovf_set, cmpa_set, ovf_clr, cmpa_clr;
  logic [7:0] top, ocr_shadow, ocr_live;
  logic oc;

  // ****************************************
  // mode decode
  // ****************************************
  always_comb begin
    adv = ce_i && tick_i;
    is_ctc = (q.wgm == TPWM_WGM_CTC);
    is_fast = (q.wgm == TPWM_WGM_FAST_MAX) || (q.wgm == TPWM_WGM_FAST_CMP);
    is_pc = (q.wgm == TPWM_WGM_PC_MAX) || (q.wgm == TPWM_WGM_PC_CMP);
    top_cmp = is_ctc || (q.wgm == TPWM_WGM_FAST_CMP) || (q.wgm == TPWM_WGM_PC_CMP);
    top = top_cmp ? ocr_live : TPWM_MAX;
    at_top = (q.cnt == top);
    // a count write masks the match on the following tick
    match = (q.cnt == ocr_live) && !q.blk;
    cnt_wr = wr_i && (addr_i == TPWM_ADDR_COUNT);
    cmp_wr = wr_i && (addr_i == TPWM_ADDR_CMPA);
    cmp_upd = adv && ((is_fast && at_top) || (is_pc && at_top && (q.dir == TPWM_DIR_UP)));
  end

  // ****************************************
  // flag events
  // ****************************************
  always_comb begin
    ovf_set = 1'b0;
    if (adv) begin
      if (is_fast) begin
        ovf_set = at_top;
      end else if (is_pc) begin
        ovf_set = (q.dir == TPWM_DIR_DOWN) && (q.cnt == TPWM_BOTTOM);
      end else begin
        ovf_set = (q.cnt == TPWM_MAX);
      end
    end
    cmpa_set = adv && match;
    ovf_clr = ovf_ack_i || (wr_i && (addr_i == TPWM_ADDR_FLAGS) && wdata_i[TPWM_FLAG_OVF_BIT]);
    cmpa_clr = cmpa_ack_i || (wr_i && (addr_i == TPWM_ADDR_FLAGS) && wdata_i[TPWM_FLAG_CMPA_BIT]);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    if (ce_i) begin
      d.rdata = TPWM_BOTTOM;
      if (rd_i) begin
        case (addr_i)
          TPWM_ADDR_CTRL: d.rdata = {q.act, 3'h0, q.wgm};
          TPWM_ADDR_COUNT: d.rdata = q.cnt;
          TPWM_ADDR_CMPA: d.rdata = ocr_shadow;
          TPWM_ADDR_FLAGS: d.rdata = {6'h00, q.cmpa, q.ovf};
          TPWM_ADDR_IRQEN: d.rdata = {6'h00, q.irq_en};
          default: d.rdata = TPWM_BOTTOM;
        endcase
      end
      if (adv) begin
        d.blk = 1'b0;
        if (is_ctc) begin
          // clear on match, otherwise wrap through max
          d.cnt = match ? TPWM_BOTTOM : q.cnt + TPWM_ONE;
        end else if (is_fast) begin
          d.cnt = at_top ? TPWM_BOTTOM : q.cnt + TPWM_ONE;
        end else if (is_pc) begin
          if (q.dir == TPWM_DIR_UP) begin
            if (at_top) begin
              d.dir = TPWM_DIR_DOWN;
              d.cnt = (top == TPWM_BOTTOM) ? TPWM_BOTTOM : q.cnt - TPWM_ONE;
            end else begin
              d.cnt = q.cnt + TPWM_ONE;
            end
          end else if (q.cnt == TPWM_BOTTOM) begin
            d.dir = TPWM_DIR_UP;
            d.cnt = (top == TPWM_BOTTOM) ? TPWM_BOTTOM : TPWM_ONE;
          end else begin
            d.cnt = q.cnt - TPWM_ONE;
          end
        end else begin
          d.cnt = q.cnt + TPWM_ONE;
        end
      end
      d.ovf = (q.ovf && !ovf_clr) || ovf_set;
      d.cmpa = (q.cmpa && !cmpa_clr) || cmpa_set;
      if (wr_i) begin
        case (addr_i)
          TPWM_ADDR_CTRL: begin
            d.act = tpwm_act_t'(wdata_i[TPWM_CTRL_ACT_LSB +: 2]);
            d.wgm = tpwm_wgm_t'(wdata_i[TPWM_CTRL_WGM_LSB +: 3]);
          end
          TPWM_ADDR_COUNT: begin
            d.cnt = wdata_i;
            d.blk = 1'b1;
          end
          TPWM_ADDR_IRQEN: d.irq_en = wdata_i[1:0];
          default: d.irq_en = q.irq_en;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{cnt: TPWM_CNT_RST, dir: TPWM_DIR_UP, ovf: 1'b0, cmpa: 1'b0, blk: 1'b0,
             wgm: TPWM_WGM_NORMAL, act: TPWM_ACT_NONE, irq_en: 2'b00, rdata: TPWM_BOTTOM};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // compare value and waveform
  // ****************************************
  tpwm_cmp_buf u_cmp (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .wr_i(cmp_wr),
    .wdata_i(wdata_i),
    .direct_i(!(is_fast || is_pc)),
    .update_i(cmp_upd),
    .shadow_o(ocr_shadow),
    .live_o(ocr_live)
  );

  tpwm_wave u_wave (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .adv_i(adv),
    .wgm_i(q.wgm),
    .act_i(q.act),
    .dir_i(q.dir),
    .cnt_i(q.cnt),
    .ocr_i(ocr_live),
    .top_i(top),
    .match_i(match),
    .oc_o(oc)
  );

  // ****************************************
  // outputs
  // ****************************************
  // pin driven only with direction set to output
  assign compare_output_a_oe_o = dir_out_i && (q.act != TPWM_ACT_NONE);
  assign compare_output_a_o = oc;
  assign rdata_o = q.rdata;
  assign ovf_irq_o = q.ovf && q.irq_en[TPWM_FLAG_OVF_BIT];
  assign cmpa_irq_o = q.cmpa && q.irq_en[TPWM_FLAG_CMPA_BIT];
  assign timer_count_o = q.cnt;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence ctc_hit_s;
    adv && is_ctc && match && !cnt_wr;
  endsequence

  sequence pc_turn_s;
    adv && is_pc && (q.dir == TPWM_DIR_UP) && at_top && (top > TPWM_ONE) && !cnt_wr;
  endsequence

  ctc_clear_a: assert property (ctc_hit_s |=> (q.cnt == TPWM_BOTTOM))
    else $error("counter not cleared after compare A match");

  ctc_wrap_a: assert property (adv && is_ctc && !match && (q.cnt == TPWM_MAX) && !cnt_wr
                               |=> (q.cnt == TPWM_BOTTOM) && q.ovf)
    else $error("counter did not wrap to zero with overflow flag");

  ctc_toggle_a: assert property ((ctc_hit_s and (q.act == TPWM_ACT_TOGGLE))
                                 |=> (oc != $past(oc)))
    else $error("compare output did not toggle on match");

  cmpa_flag_a: assert property (adv && match |=> q.cmpa)
    else $error("compare flag not set after match");

  fast_restart_a: assert property (adv && is_fast && at_top && !cnt_wr
                                   |=> (q.cnt == TPWM_BOTTOM) && q.ovf)
    else $error("fast pwm did not restart at top");

  fast_bottom_set_a: assert property (adv && is_fast && at_top && (q.act == TPWM_ACT_CLEAR)
                                      |=> oc)
    else $error("fast pwm output not set at bottom");

  pc_top_hold_a: assert property (pc_turn_s |=> (q.dir == TPWM_DIR_DOWN) && (q.cnt == $past(q.cnt) - TPWM_ONE))
    else $error("phase correct did not turn at top");

  pc_bottom_ovf_a: assert property (adv && is_pc && (q.dir == TPWM_DIR_DOWN) && (q.cnt == TPWM_BOTTOM)
                                    |=> q.ovf && (q.dir == TPWM_DIR_UP))
    else $error("phase correct bottom did not set overflow");

  pin_gate_a: assert property (!dir_out_i |-> !compare_output_a_oe_o)
    else $error("pin driven while direction is input");

  tick_freeze_a: assert property (!adv && !(ce_i && cnt_wr) |=> $stable(q.cnt) && $stable(oc))
    else $error("counter or output moved without a tick");

  no_action_a: assert property (q.act == TPWM_ACT_NONE && $stable(q.act) |=> $stable(oc))
    else $error("output changed with no action selected");

  ctc_count_a: assert property (adv && is_ctc && !match && !cnt_wr
                                |=> (q.cnt == $past(q.cnt) + TPWM_ONE))
    else $error("counter did not step up without a match");

  ctc_flag_a: assert property (ctc_hit_s |=> q.cmpa)
    else $error("compare flag not set at top");

  fast_count_a: assert property (adv && is_fast && !at_top && !cnt_wr
                                 |=> (q.cnt == $past(q.cnt) + TPWM_ONE))
    else $error("fast pwm did not count up below top");

  fast_match_clr_a: assert property (adv && is_fast && match && !at_top && (q.act == TPWM_ACT_CLEAR)
                                     |=> !oc)
    else $error("fast pwm output not cleared on match");

  fast_match_set_a: assert property (adv && is_fast && match && !at_top && (q.act == TPWM_ACT_SET)
                                     |=> oc)
    else $error("fast pwm output not set on match");

  fast_bottom_clr_a: assert property (adv && is_fast && at_top && (q.act == TPWM_ACT_SET)
                                      |=> !oc)
    else $error("inverted fast pwm output not cleared at bottom");

  fast_toggle_a: assert property (adv && is_fast && match && (q.act == TPWM_ACT_TOGGLE)
                                  |=> (oc != $past(oc)))
    else $error("fast pwm output did not toggle on match");

  pc_count_up_a: assert property (adv && is_pc && (q.dir == TPWM_DIR_UP) && !at_top && !cnt_wr
                                  |=> (q.cnt == $past(q.cnt) + TPWM_ONE) && (q.dir == TPWM_DIR_UP))
    else $error("phase correct did not count up");

  pc_count_down_a: assert property (adv && is_pc && (q.dir == TPWM_DIR_DOWN) && (q.cnt != TPWM_BOTTOM) && !cnt_wr
                                    |=> (q.cnt == $past(q.cnt) - TPWM_ONE) && (q.dir == TPWM_DIR_DOWN))
    else $error("phase correct did not count down");

  pc_down_set_a: assert property (adv && is_pc && (q.dir == TPWM_DIR_DOWN) && match && (ocr_live != TPWM_BOTTOM)
                                  && (q.act == TPWM_ACT_CLEAR) |=> oc)
    else $error("phase correct output not set on down match");

  pc_down_clr_a: assert property (adv && is_pc && (q.dir == TPWM_DIR_DOWN) && match && (ocr_live != TPWM_BOTTOM)
                                  && (q.act == TPWM_ACT_SET) |=> !oc)
    else $error("inverted phase correct output not cleared on down match");

  flag_freeze_a: assert property (!adv && !q.ovf && !q.cmpa |=> !q.ovf && !q.cmpa)
    else $error("flag set without a timer tick");

  cmpa_hold_a: assert property (q.cmpa && !cmpa_clr |=> q.cmpa)
    else $error("compare flag lost without a clear");

endmodule
`default_nettype wire

// ==== tpwm_wave.sv ====
// compare output A waveform state for all counting modes
// assumes counter state and match come from the same cycle's register values
`timescale 1ns/1ps
`default_nettype none
module tpwm_wave
  import tpwm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic adv_i,
  // counter view
  input wire tpwm_wgm_t wgm_i,
  input wire tpwm_act_t act_i,
  input wire tpwm_dir_t dir_i,
  input wire logic [7:0] cnt_i,
  input wire logic [7:0] ocr_i,
  input wire logic [7:0] top_i,
  input wire logic match_i,
  // output state
  output logic oc_o
);
  typedef struct packed {
    logic oc;
    logic up_done;
    logic was_max;
  } tpwm_wave_st_t;

  tpwm_wave_st_t q, d;
  logic at_top, bottom, up_done_eff, up_hit, dn_hit;

  always_comb begin
    d = q;
    at_top = (cnt_i == top_i);
    bottom = (dir_i == TPWM_DIR_DOWN) && (cnt_i == TPWM_BOTTOM);
    up_done_eff = q.up_done && !bottom;
    // a missed up match, or leaving the top value, still yields the up-match level
    up_hit = !up_done_eff && (ocr_i != top_i) &&
             (((dir_i == TPWM_DIR_UP) && (cnt_i >= ocr_i) && !at_top) ||
              (bottom && ((ocr_i == TPWM_BOTTOM) || q.was_max)));
    // no down match at bottom and no up match at top keep the level constant
    dn_hit = match_i && ((dir_i == TPWM_DIR_DOWN) || at_top) && (ocr_i != TPWM_BOTTOM);
    if (adv_i) begin
      case (wgm_i)
        TPWM_WGM_FAST_MAX, TPWM_WGM_FAST_CMP: begin
          if (act_i == TPWM_ACT_TOGGLE) begin
            if (match_i) d.oc = !q.oc;
          end else if (act_i != TPWM_ACT_NONE) begin
            // restart wins so a compare at top gives a constant level
            if (at_top) d.oc = (act_i == TPWM_ACT_CLEAR);
            else if (match_i) d.oc = (act_i == TPWM_ACT_SET);
          end
        end
        TPWM_WGM_PC_MAX, TPWM_WGM_PC_CMP: begin
          if (act_i == TPWM_ACT_TOGGLE) begin
            if (match_i) d.oc = !q.oc;
          end else if (act_i != TPWM_ACT_NONE) begin
            if (up_hit) d.oc = (act_i == TPWM_ACT_SET);
            else if (dn_hit) d.oc = (act_i == TPWM_ACT_CLEAR);
          end
          d.up_done = up_hit || (up_done_eff && !dn_hit);
          if (bottom) d.was_max = (ocr_i == top_i);
        end
        default: begin
          if (match_i) begin
            case (act_i)
              TPWM_ACT_TOGGLE: d.oc = !q.oc;
              TPWM_ACT_CLEAR: d.oc = 1'b0;
              TPWM_ACT_SET: d.oc = 1'b1;
              default: d.oc = q.oc;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{oc: 1'b0, up_done: 1'b0, was_max: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign oc_o = q.oc;
endmodule
`default_nettype wire
